//--- design/gpio_port_pkg.sv
package gpio_port_pkg;
  // Port geometry and bus shape
  localparam int PIN_COUNT = 5;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // Register word addresses
  localparam logic [3:0] A_INDEX = 4'h0;
  localparam logic [3:0] A_VALUE = 4'h1;
  localparam logic [3:0] A_CONFIG = 4'h2;
  localparam logic [3:0] A_EXEC = 4'h3;
  localparam logic [3:0] A_BOOT = 4'h4;
  localparam logic [3:0] A_REPLY = 4'h5;
  localparam logic [3:0] A_QUERY = 4'h6;
  localparam logic [3:0] A_PIN = 4'h7;

  // Command field limits and reply code
  localparam logic [7:0] PIN_LAST = 8'h04;
  localparam logic [7:0] VAL_HIGH = 8'h64;
  localparam logic [7:0] CFG_MAX = 8'h0f;
  localparam logic [7:0] LEN_VALUE = 8'h02;
  localparam logic [7:0] LEN_CONFIG = 8'h03;
  localparam logic [7:0] REPLY_SET_PIN = 8'h62;
  localparam logic [7:0] REPLY_NONE = 8'h00;

  // Field positions
  localparam int FUNC_BIT = 3;
  localparam int BOOT_STORE_BIT = 0;
  localparam int BOOT_RESTORE_BIT = 1;
  localparam int PIN_STATE_BIT = 0;
  localparam int PIN_RISE_BIT = 1;
  localparam int PIN_FALL_BIT = 2;
  localparam int PIN_VAL_LSB = 8;
  localparam int PIN_CFG_LSB = 16;
  localparam int REPLY_VALID_BIT = 8;
  localparam int REPLY_REJECT_BIT = 9;

  // Drive modes in the low three config bits
  localparam logic [2:0] MODE_FAST_UP = 3'h0;
  localparam logic [2:0] MODE_FAST_BOTH = 3'h1;
  localparam logic [2:0] MODE_HIZ = 3'h2;
  localparam logic [2:0] MODE_PULL_UP = 3'h3;
  localparam logic [2:0] MODE_SLOW_UP = 3'h4;
  localparam logic [2:0] MODE_SLOW_BOTH = 3'h5;
  localparam logic [2:0] MODE_RESERVED = 3'h6;
  localparam logic [2:0] MODE_SLOW_DOWN = 3'h7;

  // Electrical state of one pin
  typedef struct packed {
    logic oe;
    logic o;
    logic pull_en;
    logic pull_up;
    logic slow;
  } drive_t;

  // Factory state: pin 0 idle input, 1 sense, 2/3 control, 4 one-wire
  localparam logic [7:0] VAL_RESET = 8'h00;
  localparam logic [PIN_COUNT-1:0][7:0] CFG_RESET =
    {8'h03, 8'h02, 8'h02, 8'h03, 8'h02};

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int SAMPLE_HZ = 32;
  localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam logic [6:0] PHASE_LAST = 7'(PWM_STEPS - 1);
endpackage

//--- design/track_if.sv
`timescale 1ns/1ns
// Sampled levels in, debounced state and edge flags out
interface track_if #(parameter int N = 5);
  logic sample_tick;
  logic [N-1:0] level;
  logic [N-1:0] clear;
  logic [N-1:0] state;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src(output sample_tick, level, clear, input state, rise, fall);
  modport trk(input sample_tick, level, clear, output state, rise, fall);
endinterface

//--- design/rate_tick.sv
`timescale 1ns/1ns
module rate_tick #(
  parameter int PERIOD = 2
) (
  input wire logic clk,
  input wire logic nrst,
  output logic tick_ff
);
  localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_ff;

  // Free-running divider, one-cycle pulse per period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  tick_space_a: assert property (@(posedge clk) disable iff (!nrst)
    tick_ff |=> !tick_ff)
    else $error("divider pulses twice in a row");
endmodule

//--- design/edge_tracker.sv
`timescale 1ns/1ns
module edge_tracker #(
  parameter int N = 5
) (
  input wire logic clk,
  input wire logic nrst,
  track_if.trk trk
);
  logic primed_ff;

  // First sample after reset loads state without reporting an edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      primed_ff <= 1'b0;
    end else if (trk.sample_tick) begin
      primed_ff <= 1'b1;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_pin
    logic smp_ff;
    logic st_ff;
    logic rise_ff;
    logic fall_ff;
    logic moved;

    // Two equal samples in a row are needed, so bounce is ignored
    assign moved = primed_ff && (smp_ff == trk.level[i])
                   && (trk.level[i] != st_ff);

    always_ff @(posedge clk) begin
      if (!nrst) begin
        smp_ff <= 1'b0;
        st_ff <= 1'b0;
      end else if (trk.sample_tick) begin
        smp_ff <= trk.level[i];
        if (!primed_ff || moved) begin
          st_ff <= trk.level[i];
        end
      end
    end

    // Sticky flags; a new edge beats a clear in the same cycle
    always_ff @(posedge clk) begin
      if (!nrst) begin
        rise_ff <= 1'b0;
        fall_ff <= 1'b0;
      end else begin
        rise_ff <= (trk.sample_tick && moved && trk.level[i])
                   || (rise_ff && !trk.clear[i]);
        fall_ff <= (trk.sample_tick && moved && !trk.level[i])
                   || (fall_ff && !trk.clear[i]);
      end
    end

    assign trk.state[i] = st_ff;
    assign trk.rise[i] = rise_ff;
    assign trk.fall[i] = fall_ff;
  end

  state_on_tick_a: assert property (@(posedge clk) disable iff (!nrst)
    (g_pin[0].st_ff != $past(g_pin[0].st_ff)) |-> $past(trk.sample_tick))
    else $error("pin state moved outside a sample tick");

  flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (trk.clear[0] && !trk.sample_tick) |=> !trk.rise[0] && !trk.fall[0])
    else $error("edge flags survived a query read");

  bounce_reject_a: assert property (@(posedge clk) disable iff (!nrst)
    (trk.sample_tick && primed_ff && g_pin[0].smp_ff != trk.level[0])
    |=> $stable(trk.state[0]) && !$rose(trk.rise[0]))
    else $error("single differing sample changed pin state");
endmodule

//--- design/gpio_port.sv
`timescale 1ns/1ns
// How it works
// - Pin index 0..4 addresses a pin; 5..255 address nothing.
// - Length 2 updates output value only; length 3 also updates config.
// - Value zero gives a low level, shaped by the drive mode.
// - Values 1..99 give 100 Hz PWM with that duty percentage.
// - Value 100 holds high; 101..255 are invalid and never sent.
// - Config byte 0..15: low three bits drive mode, bit 3 function.
// - Modes 000, 001, 011 give fast strong drive or resistive pull.
// - Mode 010 floats the pin for input; code 110 is reserved.
// - Modes 100, 101, 111 give slow strong drive or float.
// - Drive mode maps each instantaneous level, PWM included, to pin state.
// - Function bit one gives user control; zero gives default role.
// - Default roles: pin 1 sense, 2 power, 3 reset, 4 one-wire.
// - Every pin level is sampled at 32 Hz regardless of queries.
// - Rising and falling edges between host queries are recorded per pin.
// - Sampling rejects contact bounce so no spurious edges appear.
// - Pull-up mode with open switch reads one, closed reads zero.
// - Pin configuration is saved to boot state and restored by a boot restore write; reset loads the factory state.
// - An accepted set command answers with reply type 0x62.
module gpio_port #(
  parameter int SAMPLE_CYC = gpio_port_pkg::SAMPLE_CYC,
  parameter int STEP_CYC = gpio_port_pkg::PWM_STEP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] addr,
  input wire logic [gpio_port_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [gpio_port_pkg::DATA_W-1:0] rdata_ff,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_in,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0] alt_level,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_out_ff,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_oe_ff,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_pull_en_ff,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_pull_up_ff,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_slow_ff
);
  localparam int N = gpio_port_pkg::PIN_COUNT;

  // Valid pin index check, shared by command and query paths
  function automatic logic idx_ok(input logic [7:0] idx);
    idx_ok = (idx <= gpio_port_pkg::PIN_LAST);
  endfunction

  // Electrical state for a drive mode and an instantaneous level
  function automatic gpio_port_pkg::drive_t drive_decode(
    input logic [2:0] mode, input logic lvl);
    gpio_port_pkg::drive_t d;
    d = '0;
    case (mode)
      gpio_port_pkg::MODE_FAST_UP: begin
        d.oe = lvl;
        d.o = 1'b1;
        d.pull_en = !lvl;
      end
      gpio_port_pkg::MODE_FAST_BOTH: begin
        d.oe = 1'b1;
        d.o = lvl;
      end
      gpio_port_pkg::MODE_PULL_UP: begin
        d.oe = !lvl;
        d.pull_en = lvl;
        d.pull_up = 1'b1;
      end
      gpio_port_pkg::MODE_SLOW_UP: begin
        d.oe = lvl;
        d.o = 1'b1;
        d.slow = 1'b1;
      end
      gpio_port_pkg::MODE_SLOW_BOTH: begin
        d.oe = 1'b1;
        d.o = lvl;
        d.slow = 1'b1;
      end
      gpio_port_pkg::MODE_SLOW_DOWN: begin
        d.oe = !lvl;
        d.slow = 1'b1;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  // Command staging, live settings and boot copy
  logic [7:0] cmd_idx_ff;
  logic [7:0] cmd_val_ff;
  logic [7:0] cmd_cfg_ff;
  logic [7:0] qidx_ff;
  logic [N-1:0][7:0] val_ff;
  logic [N-1:0][7:0] cfg_ff;
  logic [N-1:0][7:0] boot_val_ff;
  logic [N-1:0][7:0] boot_cfg_ff;
  logic [7:0] reply_type_ff;
  logic reply_vld_ff;
  logic reply_rej_ff;
  logic [6:0] phase_ff;
  logic step_tick;
  logic [N-1:0] sync1_ff;
  logic [N-1:0] sync2_ff;

  track_if #(.N(N)) trk_bus();

  // Decode of the execute write
  logic exec_wr;
  logic len_value;
  logic len_config;
  logic cmd_ok;
  logic accept;
  logic [2:0] cmd_slot;
  logic [2:0] q_slot;

  assign exec_wr = wr && (addr == gpio_port_pkg::A_EXEC);
  assign len_value = (wdata[7:0] == gpio_port_pkg::LEN_VALUE);
  assign len_config = (wdata[7:0] == gpio_port_pkg::LEN_CONFIG);
  assign cmd_ok = (len_value || len_config) && idx_ok(cmd_idx_ff)
                  && (cmd_val_ff <= gpio_port_pkg::VAL_HIGH)
                  && (!len_config
                      || cmd_cfg_ff <= gpio_port_pkg::CFG_MAX);
  assign accept = exec_wr && cmd_ok;
  assign cmd_slot = cmd_idx_ff[2:0];
  assign q_slot = qidx_ff[2:0];

  // Staging registers written one field at a time
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_idx_ff <= '0;
      cmd_val_ff <= '0;
      cmd_cfg_ff <= '0;
      qidx_ff <= '0;
    end else if (wr) begin
      case (addr)
        gpio_port_pkg::A_INDEX: cmd_idx_ff <= wdata[7:0];
        gpio_port_pkg::A_VALUE: cmd_val_ff <= wdata[7:0];
        gpio_port_pkg::A_CONFIG: cmd_cfg_ff <= wdata[7:0];
        gpio_port_pkg::A_QUERY: qidx_ff <= wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Live pin settings; a restore overrides an accepted command in that cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      val_ff <= {N{gpio_port_pkg::VAL_RESET}};
      cfg_ff <= gpio_port_pkg::CFG_RESET;
    end else if (wr && addr == gpio_port_pkg::A_BOOT
                 && wdata[gpio_port_pkg::BOOT_RESTORE_BIT]) begin
      val_ff <= boot_val_ff;
      cfg_ff <= boot_cfg_ff;
    end else if (accept) begin
      val_ff[cmd_slot] <= cmd_val_ff;
      if (len_config) begin
        cfg_ff[cmd_slot] <= cmd_cfg_ff;
      end
    end
  end

  // Boot copy survives until the next full reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      boot_val_ff <= {N{gpio_port_pkg::VAL_RESET}};
      boot_cfg_ff <= gpio_port_pkg::CFG_RESET;
    end else if (wr && addr == gpio_port_pkg::A_BOOT
                 && wdata[gpio_port_pkg::BOOT_STORE_BIT]) begin
      boot_val_ff <= val_ff;
      boot_cfg_ff <= cfg_ff;
    end
  end

  // Reply slot: new reply wins over a read that clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reply_type_ff <= gpio_port_pkg::REPLY_NONE;
      reply_vld_ff <= 1'b0;
      reply_rej_ff <= 1'b0;
    end else if (exec_wr) begin
      reply_type_ff <= accept ? gpio_port_pkg::REPLY_SET_PIN
                              : gpio_port_pkg::REPLY_NONE;
      reply_vld_ff <= 1'b1;
      reply_rej_ff <= !accept;
    end else if (rd && addr == gpio_port_pkg::A_REPLY) begin
      reply_vld_ff <= 1'b0;
    end
  end

  // 100 steps per PWM period from the system clock
  rate_tick #(.PERIOD(STEP_CYC)) u_step (
    .clk(clk),
    .nrst(nrst),
    .tick_ff(step_tick)
  );

  // Free-running phase counter shared by all pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_ff <= '0;
    end else if (step_tick) begin
      phase_ff <= (phase_ff == gpio_port_pkg::PHASE_LAST) ? '0
                  : phase_ff + 7'h01;
    end
  end

  // Pin drive; default role takes its level from the sharing logic
  logic [N-1:0] nxt_out;
  logic [N-1:0] nxt_oe;
  logic [N-1:0] nxt_pull_en;
  logic [N-1:0] nxt_pull_up;
  logic [N-1:0] nxt_slow;

  always_comb begin
    gpio_port_pkg::drive_t d;
    logic lvl;
    d = '0;
    lvl = 1'b0;
    nxt_out = '0;
    nxt_oe = '0;
    nxt_pull_en = '0;
    nxt_pull_up = '0;
    nxt_slow = '0;
    for (int i = 0; i < N; i++) begin
      // Value 0 never beats the phase, 100 always does
      lvl = cfg_ff[i][gpio_port_pkg::FUNC_BIT]
            ? ({1'b0, phase_ff} < val_ff[i]) : alt_level[i];
      d = drive_decode(cfg_ff[i][2:0], lvl);
      nxt_out[i] = d.o;
      nxt_oe[i] = d.oe;
      nxt_pull_en[i] = d.pull_en;
      nxt_pull_up[i] = d.pull_up;
      nxt_slow[i] = d.slow;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      pin_pull_en_ff <= '0;
      pin_pull_up_ff <= '0;
      pin_slow_ff <= '0;
    end else begin
      pin_out_ff <= nxt_out;
      pin_oe_ff <= nxt_oe;
      pin_pull_en_ff <= nxt_pull_en;
      pin_pull_up_ff <= nxt_pull_up;
      pin_slow_ff <= nxt_slow;
    end
  end

  // Pins are asynchronous to clk; two flops before the tracker
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // 32 Hz sampling, long count kept as a parameter
  rate_tick #(.PERIOD(SAMPLE_CYC)) u_sample (
    .clk(clk),
    .nrst(nrst),
    .tick_ff(trk_bus.sample_tick)
  );

  assign trk_bus.level = sync2_ff;
  assign trk_bus.clear = (rd && addr == gpio_port_pkg::A_PIN
                          && idx_ok(qidx_ff))
                         ? (N'(1) << q_slot) : '0;

  edge_tracker #(.N(N)) u_track (
    .clk(clk),
    .nrst(nrst),
    .trk(trk_bus)
  );

  // Read data only in the cycle after the strobe
  logic [gpio_port_pkg::DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (rd) begin
      case (addr)
        gpio_port_pkg::A_INDEX: nxt_rdata[7:0] = cmd_idx_ff;
        gpio_port_pkg::A_VALUE: nxt_rdata[7:0] = cmd_val_ff;
        gpio_port_pkg::A_CONFIG: nxt_rdata[7:0] = cmd_cfg_ff;
        gpio_port_pkg::A_QUERY: nxt_rdata[7:0] = qidx_ff;
        gpio_port_pkg::A_REPLY: begin
          nxt_rdata[7:0] = reply_type_ff;
          nxt_rdata[gpio_port_pkg::REPLY_VALID_BIT] = reply_vld_ff;
          nxt_rdata[gpio_port_pkg::REPLY_REJECT_BIT] = reply_rej_ff;
        end
        gpio_port_pkg::A_PIN: begin
          // Reserved index reads as zero
          if (idx_ok(qidx_ff)) begin
            nxt_rdata[gpio_port_pkg::PIN_STATE_BIT] = trk_bus.state[q_slot];
            nxt_rdata[gpio_port_pkg::PIN_RISE_BIT] = trk_bus.rise[q_slot];
            nxt_rdata[gpio_port_pkg::PIN_FALL_BIT] = trk_bus.fall[q_slot];
            nxt_rdata[gpio_port_pkg::PIN_VAL_LSB +: 8] = val_ff[q_slot];
            nxt_rdata[gpio_port_pkg::PIN_CFG_LSB +: 8] = cfg_ff[q_slot];
          end
        end
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence exec_ok_s;
    accept && !(wr && addr == gpio_port_pkg::A_BOOT);
  endsequence

  sequence exec_bad_s;
    exec_wr && !cmd_ok;
  endsequence

  reserved_idx_a: assert property (
    (exec_wr && !idx_ok(cmd_idx_ff)) |=> $stable(val_ff) && $stable(cfg_ff))
    else $error("reserved index changed a pin setting");

  bad_cmd_a: assert property (
    exec_bad_s |=> $stable(val_ff) && $stable(cfg_ff) && reply_rej_ff)
    else $error("rejected command altered settings");

  reply_code_a: assert property (
    exec_ok_s |=> reply_vld_ff && !reply_rej_ff
                  && reply_type_ff == gpio_port_pkg::REPLY_SET_PIN)
    else $error("accepted command gave wrong reply");

  value_only_a: assert property (
    (exec_ok_s and len_value) |=> $stable(cfg_ff)
      && val_ff[$past(cmd_slot)] == $past(cmd_val_ff))
    else $error("two-byte command touched config");

  low_level_a: assert property (
    (cfg_ff[0][3:0] == 4'h9 && val_ff[0] == 8'h00) [*2]
    |-> pin_oe_ff[0] && !pin_out_ff[0])
    else $error("value zero did not drive low");

  high_level_a: assert property (
    (cfg_ff[0][3:0] == 4'h9 && val_ff[0] == gpio_port_pkg::VAL_HIGH)
    |=> pin_oe_ff[0] && pin_out_ff[0])
    else $error("value 100 did not hold high");

  pwm_duty_a: assert property (
    cfg_ff[0][3:0] == 4'hd
    |=> pin_out_ff[0] == ($past({1'b0, phase_ff}) < $past(val_ff[0])))
    else $error("PWM level disagrees with phase and duty");

  hiz_mode_a: assert property (
    cfg_ff[2][2:0] == gpio_port_pkg::MODE_HIZ |=> !pin_oe_ff[2]
      && !pin_pull_en_ff[2])
    else $error("input mode drove the pin");

  phase_wrap_a: assert property (
    (step_tick && phase_ff == gpio_port_pkg::PHASE_LAST)
    |=> phase_ff == 7'h00)
    else $error("phase counter did not wrap at 99");

  boot_restore_a: assert property (
    (wr && addr == gpio_port_pkg::A_BOOT
     && wdata[gpio_port_pkg::BOOT_RESTORE_BIT])
    |=> cfg_ff == $past(boot_cfg_ff) && val_ff == $past(boot_val_ff))
    else $error("restore did not load boot state");
endmodule

//--- sim/pad_model.sv
`timescale 1ns/1ns
// Pads with a switch to ground on each; resolves the wire seen by the port
module pad_model (
  input wire logic clk,
  input wire logic [4:0] oe,
  input wire logic [4:0] o,
  input wire logic [4:0] pe,
  input wire logic [4:0] pu,
  input wire logic [4:0] sw_closed,
  output logic [4:0] pin_in
);
  logic tog_ff = 1'b0;

  // Floating pads change every cycle so no stale level can pass as valid
  always @(posedge clk) begin
    tog_ff <= ~tog_ff;
  end

  // Strong drive wins, then a closed switch, then the resistive pull
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (oe[i])
        pin_in[i] = o[i];
      else if (sw_closed[i])
        pin_in[i] = 1'b0;
      else if (pe[i])
        pin_in[i] = pu[i];
      else
        pin_in[i] = tog_ff ^ i[0];
    end
  end
endmodule

//--- sim/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_ff;
  logic [4:0] pin_in;
  logic [4:0] alt_level = 5'h00;
  logic [4:0] sw_closed = 5'h00;
  logic [4:0] pin_out_ff, pin_oe_ff, pin_pull_en_ff;
  logic [4:0] pin_pull_up_ff, pin_slow_ff;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Expected {oe, pull, slow, level} indexed by {mode, level}
  localparam logic [3:0] DRV [16] = '{4'h4, 4'h9, 4'h8, 4'h9, 4'h0, 4'h0,
    4'h8, 4'h5, 4'h0, 4'hb, 4'ha, 4'hb, 4'h0, 4'h0, 4'ha, 4'h0};
  localparam logic [7:0] CFG_FAC [5] = '{8'h02, 8'h03, 8'h02, 8'h02, 8'h03};
  // Illegal commands: index, value, config, length
  localparam logic [7:0] BAD [4][4] = '{'{8'h05, 8'h00, 8'h09, 8'h03},
    '{8'h00, 8'h65, 8'h09, 8'h03}, '{8'h00, 8'h00, 8'h10, 8'h03},
    '{8'hff, 8'h00, 8'h09, 8'h02}};

  gpio_port #(.SAMPLE_CYC(20), .STEP_CYC(20)) gpio_port_i (.clk(clk),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff),
    .pin_in(pin_in), .alt_level(alt_level), .pin_out_ff(pin_out_ff),
    .pin_oe_ff(pin_oe_ff), .pin_pull_en_ff(pin_pull_en_ff),
    .pin_pull_up_ff(pin_pull_up_ff), .pin_slow_ff(pin_slow_ff));

  pad_model pad_model_i (.clk(clk), .oe(pin_oe_ff), .o(pin_out_ff),
    .pe(pin_pull_en_ff), .pu(pin_pull_up_ff), .sw_closed(sw_closed),
    .pin_in(pin_in));

  initial begin
    forever #25 clk = ~clk;
  end

  // Cycles since reset release, to predict the free PWM phase
  always @(posedge clk) begin
    cyc <= nrst ? cyc + 1 : 0;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata_ff;
  endtask

  task automatic cmd(input logic [7:0] i, input logic [7:0] v,
                     input logic [7:0] c, input logic [7:0] n);
    wr_reg(gpio_port_pkg::A_INDEX, {24'h0, i});
    wr_reg(gpio_port_pkg::A_VALUE, {24'h0, v});
    wr_reg(gpio_port_pkg::A_CONFIG, {24'h0, c});
    wr_reg(gpio_port_pkg::A_EXEC, {24'h0, n});
    repeat (3) @(posedge clk);
  endtask

  task automatic pin_word(input logic [7:0] i, output logic [31:0] w);
    wr_reg(gpio_port_pkg::A_QUERY, {24'h0, i});
    rd_reg(gpio_port_pkg::A_PIN, w);
  endtask

  // Pad outputs folded; a floating pad shows level 0 with oe and pull off
  function automatic logic [3:0] drv(input int p);
    logic oe;
    logic pe;
    oe = pin_oe_ff[p];
    pe = pin_pull_en_ff[p] & ~oe;
    return {oe, pe, oe & pin_slow_ff[p],
            oe ? pin_out_ff[p] : (pe & pin_pull_up_ff[p])};
  endfunction

  // A hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    $display("unexpected at %0t: run timed out", $time);
    fail_count++;
    give_verdict();
  end

  initial begin
    logic [31:0] w;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      pin_word(8'(i), w);
      cmp(w & 32'hffff00, {8'h00, CFG_FAC[i], 16'h0000});
    end
    rd_reg(4'hf, w);
    cmp(w, 32'h0);
    // Refused commands leave pin 0 at its factory setting
    for (int k = 0; k < 4; k++) begin
      cmd(BAD[k][0], BAD[k][1], BAD[k][2], BAD[k][3]);
      rd_reg(gpio_port_pkg::A_REPLY, w);
      cmp(w & 32'h3ff, 32'h300);
      pin_word(8'h00, w);
      cmp(w & 32'hffff00, 32'h020000);
    end
    cmd(8'h00, 8'h64, 8'h09, 8'h03);
    rd_reg(gpio_port_pkg::A_REPLY, w);
    cmp(w & 32'h3ff, 32'h162);
    cmp(drv(0), 4'h9);
    // Short command must ignore the pending config byte
    cmd(8'h00, 8'h00, 8'h0a, 8'h02);
    pin_word(8'h00, w);
    cmp(w & 32'hffff00, 32'h090000);
    cmp(drv(0), 4'h8);
    for (int m = 0; m < 8; m++) begin
      for (int l = 0; l < 2; l++) begin
        if (m != 6) begin
          cmd(8'h02, l ? 8'h64 : 8'h00, 8'(8 + m), 8'h03);
          cmp(drv(2), DRV[m * 2 + l]);
        end
      end
    end
    cmd(8'h02, 8'h00, 8'h02, 8'h03);
    // Default role follows the role level through the drive mode
    repeat (3) @(posedge clk);
    cmp(drv(4), 4'h8);
    alt_level <= 5'h10;
    repeat (3) @(posedge clk);
    cmp(drv(4), 4'h5);
    cmd(8'h00, 8'h64, 8'h0b, 8'h03);
    repeat (100) @(posedge clk);
    pin_word(8'h00, w);
    pin_word(8'h00, w);
    cmp(w & 32'h7, 32'h1);
    // Bounce faster than two agreeing samples
    for (int k = 0; k < 10; k++) begin
      sw_closed[0] <= ~sw_closed[0];
      repeat (20) @(posedge clk);
    end
    pin_word(8'h00, w);
    cmp(w & 32'h7, 32'h1);
    sw_closed[0] <= 1'b1;
    repeat (100) @(posedge clk);
    pin_word(8'h00, w);
    cmp(w & 32'h7, 32'h4);
    pin_word(8'h00, w);
    cmp(w & 32'h7, 32'h0);
    sw_closed[0] <= 1'b0;
    repeat (100) @(posedge clk);
    pin_word(8'h00, w);
    cmp(w & 32'h7, 32'h3);
    // Saved config comes back after being overwritten
    wr_reg(gpio_port_pkg::A_BOOT, 32'h1);
    cmd(8'h00, 8'h64, 8'h09, 8'h03);
    wr_reg(gpio_port_pkg::A_BOOT, 32'h2);
    repeat (3) @(posedge clk);
    pin_word(8'h00, w);
    cmp(w & 32'hff0000, 32'h0b0000);
    // Sample away from step edges, where counter offsets do not matter
    cmd(8'h00, 8'h1e, 8'h0d, 8'h03);
    for (int k = 0; k < 400; k++) begin
      repeat (7) @(posedge clk);
      if (cyc % 20 inside {[5:15]})
        cmp(32'(pin_out_ff[0]), 32'((cyc / 20) % 100 < 30));
    end
    give_verdict();
  end
endmodule
